// ### remote_light_and_guide_command.sv
// Decoder for network illumination and guide command words.
`timescale 1ns/1ns
`include "light_guide_defs.svh"
module remote_light_and_guide_command
   import light_guide_pkg::*;
#(
   parameter logic [15:0] GUIDE_LIMIT_STEPS = 16'h0064
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire cmd_write_t cmd,
   input wire logic [6:0] local_lower,
   input wire logic [6:0] local_upper,
   input wire light_req_t [1:0] manual_req,
   input wire light_req_t [1:0] algo_req,
   output logic [1:0][6:0] brightness,
   output logic [6:0] active_lower,
   output logic [6:0] active_upper,
   output logic [1:0] auto_light_on,
   output logic remote_control,
   output logic guide_auto_mode,
   output logic jog_left,
   output logic jog_right,
   output logic signed [15:0] guide_point
);

   state_t st_reg;
   state_t st_next;
   logic light_on;
   logic [6:0] lim_lo;
   logic [6:0] lim_hi;
   logic [1:0] auto_en;
   logic [1:0] ovr_en;
   logic [15:0] rise;
   logic guide_wr;
   logic signed [15:0] gp_max;

   // Clamps a value into a closed range, the lower bound winning a crossed pair.
   function automatic logic [6:0] clamp(input logic [6:0] v, input logic [6:0] lo,
                                        input logic [6:0] hi);
      logic [6:0] r;
      r = v;
      if (r > hi) begin
         r = hi;
      end
      if (r < lo) begin
         r = lo;
      end
      return r;
   endfunction

   // Limits a limit field to the given ceiling.
   function automatic logic [6:0] cap(input logic [6:0] v, input logic [6:0] top);
      return (v > top) ? top : v;
   endfunction

   // Decoded views of the stored words.
   assign light_on = st_reg.limits_word[`BIT_LIGHT_ENABLE];
   assign auto_en[0] = light_on ? st_reg.auto_word[`BIT_S1_AUTO] : 1'b1;
   assign auto_en[1] = light_on ? st_reg.auto_word[`BIT_S2_AUTO] : 1'b1;
   assign ovr_en[0] = light_on & st_reg.auto_word[`BIT_S1_OVR];
   assign ovr_en[1] = light_on & st_reg.auto_word[`BIT_S2_OVR];
   assign gp_max = GUIDE_LIMIT_STEPS;

   // Active limits: host pair when both enables are set, else the panel pair.
   always_comb begin
      if (light_on && st_reg.limits_word[`BIT_LIMIT_ENABLE]) begin
         lim_hi = cap(st_reg.limits_word[`UPPER_HI:`UPPER_LO], `NET_LIMIT_MAX);
         lim_lo = cap(st_reg.limits_word[`LOWER_HI:`LOWER_LO], `NET_LIMIT_MAX);
      end else begin
         lim_hi = cap(local_upper, `LOCAL_LIMIT_MAX);
         lim_lo = cap(local_lower, `LOCAL_LIMIT_MAX);
      end
   end

   // Rising bits of the guide word against the previously received word.
   assign guide_wr = cmd.valid && (cmd.addr == `ADDR_GUIDE_CMD);
   assign rise = cmd.data & ~st_reg.guide_word;

   // Next state of every stored word, brightness and guide point.
   always_comb begin
      st_next = st_reg;
      if (cmd.valid && cmd.addr == `ADDR_LIGHT_LIMITS) begin
         st_next.limits_word = cmd.data;
      end
      if (cmd.valid && cmd.addr == `ADDR_LIGHT_AUTO) begin
         st_next.auto_word = cmd.data;
      end
      // Brightness: override beats algorithm beats panel; frozen sensors hold.
      for (int s = 0; s < 2; s++) begin
         if (cmd.valid && ovr_en[s] &&
             cmd.addr == ((s == 0) ? `ADDR_OVR_ONE : `ADDR_OVR_TWO)) begin
            st_next.bright[s] = clamp({1'b0, cmd.data[`OVR_HI:0]}, lim_lo, lim_hi);
         end else if (auto_en[s] && algo_req[s].valid) begin
            st_next.bright[s] = clamp(algo_req[s].level, lim_lo, lim_hi);
         end else if (!light_on && manual_req[s].valid) begin
            st_next.bright[s] = clamp(manual_req[s].level, lim_lo, lim_hi);
         end else begin
            st_next.bright[s] = clamp(st_reg.bright[s], lim_lo, lim_hi);
         end
      end
      // Guide word is stored whole; low reserved bits drive nothing.
      if (guide_wr) begin
         st_next.guide_word = cmd.data;
         case ({cmd.data[`BIT_REMOTE], cmd.data[`BIT_AUTO_MODE]})
            2'b10: begin
               st_next.guide_state = GUIDE_REMOTE_MANUAL;
            end
            2'b11: begin
               st_next.guide_state = GUIDE_REMOTE_AUTO;
            end
            default: begin
               st_next.guide_state = GUIDE_LOCAL;
            end
         endcase
         // Single steps only for a rising bit while the host runs automatic mode.
         if (cmd.data[`BIT_REMOTE] && cmd.data[`BIT_AUTO_MODE]) begin
            if (rise[`BIT_JOG_LEFT] && !rise[`BIT_JOG_RIGHT] &&
                st_reg.guide_point > -gp_max) begin
               st_next.guide_point = st_reg.guide_point - `GUIDE_STEP;
            end else if (rise[`BIT_JOG_RIGHT] && !rise[`BIT_JOG_LEFT] &&
                         st_reg.guide_point < gp_max) begin
               st_next.guide_point = st_reg.guide_point + `GUIDE_STEP;
            end
         end
      end
   end

   // State register.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg.limits_word <= `WORD_RESET;
         st_reg.auto_word <= `WORD_RESET;
         st_reg.guide_word <= `WORD_RESET;
         st_reg.bright <= {`BRIGHT_RESET, `BRIGHT_RESET};
         st_reg.guide_point <= `WORD_RESET;
         st_reg.guide_state <= GUIDE_LOCAL;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs from the state register, active limits also from the panel inputs; jogs as levels in manual mode.
   assign brightness = st_reg.bright;
   assign active_lower = lim_lo;
   assign active_upper = lim_hi;
   assign auto_light_on = auto_en;
   assign remote_control = (st_reg.guide_state != GUIDE_LOCAL);
   assign guide_auto_mode = (st_reg.guide_state == GUIDE_REMOTE_AUTO);
   assign jog_left = (st_reg.guide_state == GUIDE_REMOTE_MANUAL) &&
                     st_reg.guide_word[`BIT_JOG_LEFT];
   assign jog_right = (st_reg.guide_state == GUIDE_REMOTE_MANUAL) &&
                      st_reg.guide_word[`BIT_JOG_RIGHT];
   assign guide_point = st_reg.guide_point;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   // Brightness stays inside the active limits when they are ordered.
   property p_bright_in_range;
      (lim_lo <= lim_hi) |=>
         (brightness[0] <= $past(lim_hi)) && (brightness[0] >= $past(lim_lo)) &&
         (brightness[1] <= $past(lim_hi)) && (brightness[1] >= $past(lim_lo));
   endproperty
   a_bright_in_range: assert property (p_bright_in_range)
      else $error("brightness left the active limits");

   // With light enable clear, the panel upper limit applies regardless of the limit enable.
   property p_light_gate;
      !light_on |-> (active_upper == cap(local_upper, `LOCAL_LIMIT_MAX));
   endproperty
   a_light_gate: assert property (p_light_gate)
      else $error("host limits used without light enable");

   // Network limits never exceed 125.
   property p_net_cap;
      light_on && st_reg.limits_word[`BIT_LIMIT_ENABLE] |->
         (active_upper <= `NET_LIMIT_MAX) && (active_lower <= `NET_LIMIT_MAX);
   endproperty
   a_net_cap: assert property (p_net_cap)
      else $error("network limit above ceiling");

   // A frozen sensor ignores algorithm requests.
   property p_freeze;
      light_on && !auto_en[0] && !cmd.valid && $stable(lim_lo) && $stable(lim_hi)
         && (brightness[0] >= lim_lo) && (brightness[0] <= lim_hi)
         |=> $stable(brightness[0]);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("frozen sensor brightness moved");

   // Override writes are ignored while override is off.
   property p_ovr_refused;
      cmd.valid && cmd.addr == `ADDR_OVR_TWO && !ovr_en[1] && !auto_en[1] &&
         light_on && $stable(lim_lo) && $stable(lim_hi) |=> $stable(brightness[1]);
   endproperty
   a_ovr_refused: assert property (p_ovr_refused)
      else $error("override taken while disabled");

   // A rising left bit in remote automatic mode lowers the guide point by one.
   property p_step_down;
      guide_wr && cmd.data[`BIT_REMOTE] && cmd.data[`BIT_AUTO_MODE] &&
         rise[`BIT_JOG_LEFT] && !rise[`BIT_JOG_RIGHT] && guide_point > -gp_max
         |=> guide_point == $past(guide_point) - `GUIDE_STEP;
   endproperty
   a_step_down: assert property (p_step_down)
      else $error("guide point did not step down");

   // A held right bit never steps twice.
   property p_no_repeat;
      guide_wr && cmd.data[`BIT_JOG_RIGHT] && st_reg.guide_word[`BIT_JOG_RIGHT] &&
         !rise[`BIT_JOG_LEFT] |=> $stable(guide_point);
   endproperty
   a_no_repeat: assert property (p_no_repeat)
      else $error("guide point stepped without a rising bit");

   // The guide point never passes the extreme limit.
   property p_extreme;
      (guide_point <= gp_max) && (guide_point >= -gp_max);
   endproperty
   a_extreme: assert property (p_extreme)
      else $error("guide point past its extreme");

   // Manual jog follows the command word bit with one cycle of delay.
   property p_jog_level;
      guide_wr && cmd.data[`BIT_REMOTE] && !cmd.data[`BIT_AUTO_MODE]
         |=> jog_left == $past(cmd.data[`BIT_JOG_LEFT]) &&
             jog_right == $past(cmd.data[`BIT_JOG_RIGHT]);
   endproperty
   a_jog_level: assert property (p_jog_level)
      else $error("jog outputs do not follow the command word");

   // Local mode leaves jog outputs low and hands control back.
   property p_local;
      guide_wr && !cmd.data[`BIT_REMOTE] |=> !remote_control ##0 !jog_left ##0 !jog_right;
   endproperty
   a_local: assert property (p_local)
      else $error("local mode still driving the guide");

   // Host limit fields are used as written when they lie within the network range.
   property p_host_fields;
      light_on && st_reg.limits_word[`BIT_LIMIT_ENABLE] &&
         (st_reg.limits_word[`UPPER_HI:`UPPER_LO] <= `NET_LIMIT_MAX) &&
         (st_reg.limits_word[`LOWER_HI:`LOWER_LO] <= `NET_LIMIT_MAX)
         |-> (active_upper == st_reg.limits_word[`UPPER_HI:`UPPER_LO]) &&
             (active_lower == st_reg.limits_word[`LOWER_HI:`LOWER_LO]);
   endproperty
   a_host_fields: assert property (p_host_fields)
      else $error("host limit fields not taken from the limits word");

   // Unless both enables are set the capped panel pair stays in force.
   property p_limit_gate;
      !(light_on && st_reg.limits_word[`BIT_LIMIT_ENABLE]) |->
         (active_upper == cap(local_upper, `LOCAL_LIMIT_MAX)) &&
         (active_lower == cap(local_lower, `LOCAL_LIMIT_MAX));
   endproperty
   a_limit_gate: assert property (p_limit_gate)
      else $error("host limits used without both enables");

   // Panel limits never exceed 100.
   property p_panel_cap;
      !(light_on && st_reg.limits_word[`BIT_LIMIT_ENABLE]) |->
         (active_upper <= `LOCAL_LIMIT_MAX) && (active_lower <= `LOCAL_LIMIT_MAX);
   endproperty
   a_panel_cap: assert property (p_panel_cap)
      else $error("panel limit above ceiling");

   // Automatic bits follow the second word while light enable is set.
   property p_auto_bits;
      light_on |-> (auto_light_on[0] == st_reg.auto_word[`BIT_S1_AUTO]) &&
         (auto_light_on[1] == st_reg.auto_word[`BIT_S2_AUTO]);
   endproperty
   a_auto_bits: assert property (p_auto_bits)
      else $error("automatic bits do not follow the second word");

   // With light enable clear both sensors stay under local automatic control.
   property p_auto_free;
      !light_on |-> (&auto_light_on);
   endproperty
   a_auto_free: assert property (p_auto_free)
      else $error("automatic control gated without light enable");

   // An accepted override inside the limits becomes the sensor brightness.
   property p_ovr_taken;
      cmd.valid && cmd.addr == `ADDR_OVR_ONE && ovr_en[0] && (lim_lo <= lim_hi) &&
         ({1'b0, cmd.data[`OVR_HI:0]} >= lim_lo) && ({1'b0, cmd.data[`OVR_HI:0]} <= lim_hi)
         |=> brightness[0] == {1'b0, $past(cmd.data[`OVR_HI:0])};
   endproperty
   a_ovr_taken: assert property (p_ovr_taken)
      else $error("override value not applied");

   // An algorithm request inside the limits is taken when no override competes.
   property p_algo_taken;
      auto_en[0] && algo_req[0].valid && !(cmd.valid && cmd.addr == `ADDR_OVR_ONE) &&
         (algo_req[0].level >= lim_lo) && (algo_req[0].level <= lim_hi)
         |=> brightness[0] == $past(algo_req[0].level);
   endproperty
   a_algo_taken: assert property (p_algo_taken)
      else $error("algorithm request not applied");

   // A remote guide word hands control to the host.
   property p_remote;
      guide_wr && cmd.data[`BIT_REMOTE] |=> remote_control;
   endproperty
   a_remote: assert property (p_remote)
      else $error("host did not take control");

   // The mode bit of a remote guide word selects manual or automatic.
   property p_mode;
      guide_wr && cmd.data[`BIT_REMOTE] |=> guide_auto_mode == $past(cmd.data[`BIT_AUTO_MODE]);
   endproperty
   a_mode: assert property (p_mode)
      else $error("guide mode does not follow the mode bit");

   // A rising right bit in remote automatic mode raises the guide point by one.
   property p_step_up;
      guide_wr && cmd.data[`BIT_REMOTE] && cmd.data[`BIT_AUTO_MODE] &&
         rise[`BIT_JOG_RIGHT] && !rise[`BIT_JOG_LEFT] && guide_point < gp_max
         |=> guide_point == $past(guide_point) + `GUIDE_STEP;
   endproperty
   a_step_up: assert property (p_step_up)
      else $error("guide point did not step up");

   // Automatic mode never drives the jog outputs.
   property p_no_jog_auto;
      guide_auto_mode |-> !jog_left && !jog_right;
   endproperty
   a_no_jog_auto: assert property (p_no_jog_auto)
      else $error("jog output active in automatic mode");

   // Without a guide write the jog outputs, control and guide point hold.
   property p_guide_quiet;
      !guide_wr |=> $stable(jog_left) && $stable(jog_right) && $stable(remote_control) &&
         $stable(guide_point);
   endproperty
   a_guide_quiet: assert property (p_guide_quiet)
      else $error("guide outputs changed without a command word");

   // A word that differs from the stored one only in reserved bits changes nothing.
   property p_reserved;
      guide_wr && (cmd.data[`BIT_JOG_RIGHT:`BIT_REMOTE] ==
                   st_reg.guide_word[`BIT_JOG_RIGHT:`BIT_REMOTE])
         |=> $stable(remote_control) && $stable(guide_auto_mode) && $stable(jog_left) &&
             $stable(jog_right) && $stable(guide_point);
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved guide bits changed the guide");

   // Main scenarios.
   c_step_up: cover property (guide_wr && guide_auto_mode && rise[`BIT_JOG_RIGHT]
                              ##1 guide_point > $past(guide_point));
   c_override: cover property (cmd.valid && cmd.addr == `ADDR_OVR_ONE && ovr_en[0]);
   c_freeze: cover property (light_on && !auto_en[0] ##1 light_on && !auto_en[1]);
   c_jog: cover property (jog_left ##1 !jog_left);

endmodule

// ### light_guide_defs.svh
// Constants for the remote light and guide command decoder.
// Behaviour
// - Light enable bit 15 of the limits word gates every other brightness bit.
// - Limit enable bit 14 replaces the normal 4 to 100 range with host limits; the code replaces the panel pair capped at 100.
// - Upper limit sits in bits 13 to 7, lower limit in bits 6 to 0.
// - One limit pair serves both sensors; host keeps upper not below lower.
// - Network limits go up to 125, local panel limits only up to 100.
// - Brightness is clamped to active limits for manual and automatic changes.
// - Bits 15 and 7 of the second word enable automatic brightness per sensor.
// - Clearing an automatic bit freezes that sensor at its present brightness.
// - Bits 14 and 6 of the second word enable brightness override per sensor.
// - A 6-bit override value is taken only while its override enable is set.
// - An override written during automatic control seeds the algorithm's start.
// - Guide command bits 7 to 0 are reserved and do nothing.
// - Guide bit 8 gives the host control and locks out the local panel.
// - Guide bit 9 selects manual (zero) or automatic (one) guide mode.
// - In manual mode bit 10 jogs left while it is one.
// - In automatic mode each rise of bit 10 lowers the guide point one step; the code takes no step when bit 11 rises in the same word.
// - In manual mode bit 11 jogs right while it is one.
// - In automatic mode each rise of bit 11 raises the guide point one step; the code takes no step when bit 10 rises in the same word.
// - The guide point never passes its extreme limit.
// - Jog bits are only changed by the host, never by the device.
`ifndef LIGHT_GUIDE_DEFS_SVH
`define LIGHT_GUIDE_DEFS_SVH
`define ADDR_LIGHT_LIMITS 4'h2
`define ADDR_LIGHT_AUTO 4'h3
`define ADDR_GUIDE_CMD 4'h4
`define ADDR_OVR_ONE 4'h5
`define ADDR_OVR_TWO 4'h6
`define BIT_LIGHT_ENABLE 15
`define BIT_LIMIT_ENABLE 14
`define UPPER_HI 13
`define UPPER_LO 7
`define LOWER_HI 6
`define LOWER_LO 0
`define BIT_S1_AUTO 15
`define BIT_S2_AUTO 7
`define BIT_S1_OVR 14
`define BIT_S2_OVR 6
`define OVR_HI 5
`define BIT_REMOTE 8
`define BIT_AUTO_MODE 9
`define BIT_JOG_LEFT 10
`define BIT_JOG_RIGHT 11
`define NET_LIMIT_MAX 7'h7D
`define LOCAL_LIMIT_MAX 7'h64
`define NORMAL_LOWER 7'h04
`define NORMAL_UPPER 7'h64
`define BRIGHT_RESET 7'h32
`define WORD_RESET 16'h0000
`define GUIDE_STEP 16'h0001
`endif

// ### light_guide_pkg.sv
// Types shared by the remote light and guide command decoder.
package light_guide_pkg;
   // One command word written by the network transport.
   typedef struct packed {
      logic valid;
      logic [3:0] addr;
      logic [15:0] data;
   } cmd_write_t;
   // One brightness request from the local panel or the automatic algorithm.
   typedef struct packed {
      logic valid;
      logic [6:0] level;
   } light_req_t;
   typedef enum logic [1:0] {
      GUIDE_LOCAL = 2'b00,
      GUIDE_REMOTE_MANUAL = 2'b01,
      GUIDE_REMOTE_AUTO = 2'b10
   } guide_state_t;
   // Whole state of the decoder.
   typedef struct packed {
      logic [15:0] limits_word;
      logic [15:0] auto_word;
      logic [15:0] guide_word;
      logic [1:0][6:0] bright;
      logic signed [15:0] guide_point;
      guide_state_t guide_state;
   } state_t;
endpackage

// ### net_host_model.sv
// Model of the network host that writes command words into the decoder.
`timescale 1ns/1ns
module net_host_model
   import light_guide_pkg::*;
(
   input wire logic clk,
   output cmd_write_t cmd
);
   initial begin
      cmd = '0;
   end
   // Writes one word, valid for a single cycle, then lets the registered effect settle.
   // The host sends each data word as given, reserved guide bits and held step bits included.
   task automatic send(input logic [3:0] addr, input logic [15:0] data);
      @(posedge clk);
      cmd <= '{valid: 1'b1, addr: addr, data: data};
      @(posedge clk);
      cmd.valid <= 1'b0;
      @(posedge clk);
      @(negedge clk);
   endtask
endmodule

// ### remote_light_and_guide_command_tb.sv
// Self-checking testbench for the remote light and guide command decoder.
`timescale 1ns/1ns
module remote_light_and_guide_command_tb
   import light_guide_pkg::*;
;
   logic clk;
   logic rst_b;
   cmd_write_t cmd;
   logic [6:0] local_lower;
   logic [6:0] local_upper;
   light_req_t [1:0] manual_req;
   light_req_t [1:0] algo_req;
   logic [1:0][6:0] brightness;
   logic [6:0] active_lower;
   logic [6:0] active_upper;
   logic [1:0] auto_light_on;
   logic remote_control;
   logic guide_auto_mode;
   logic jog_left;
   logic jog_right;
   logic signed [15:0] guide_point;
   int error_cnt;
   int n_compared;

   // Small guide travel so the extreme limit is reached in a few steps.
   remote_light_and_guide_command #(
      .GUIDE_LIMIT_STEPS(16'h0003)
   ) i_remote_light_and_guide_command (
      .clk(clk), .rst_b(rst_b), .cmd(cmd), .local_lower(local_lower),
      .local_upper(local_upper), .manual_req(manual_req), .algo_req(algo_req),
      .brightness(brightness), .active_lower(active_lower), .active_upper(active_upper),
      .auto_light_on(auto_light_on), .remote_control(remote_control),
      .guide_auto_mode(guide_auto_mode), .jog_left(jog_left), .jog_right(jog_right),
      .guide_point(guide_point)
   );

   net_host_model i_net_host_model (
      .clk(clk),
      .cmd(cmd)
   );

   // Clock at 25 MHz.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Compares one value and reports a mismatch at once.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Presents one brightness request for a single cycle, from the algorithm or the panel.
   task automatic req(input bit algo, input int idx, input logic [6:0] lvl);
      @(posedge clk);
      if (algo) begin
         algo_req[idx] <= '{valid: 1'b1, level: lvl};
      end else begin
         manual_req[idx] <= '{valid: 1'b1, level: lvl};
      end
      @(posedge clk);
      algo_req[idx].valid <= 1'b0;
      manual_req[idx].valid <= 1'b0;
      @(posedge clk);
      @(negedge clk);
   endtask

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      error_cnt = 0;
      n_compared = 0;
      rst_b = 1'b0;
      local_lower = 7'h0A;
      local_upper = 7'h70;
      manual_req = '0;
      algo_req = '0;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      @(negedge clk);
      // Reset state; panel upper limit is capped at 100.
      chk(16'(brightness[0]), 16'h0032, "reset brightness");
      chk(16'(guide_point), 16'h0000, "reset guide point");
      chk(16'(auto_light_on), 16'h0003, "reset auto light");
      chk(16'(active_upper), 16'h0064, "panel upper cap");
      chk(16'(active_lower), 16'h000A, "panel lower");
      // Panel and algorithm requests are clamped to panel limits.
      req(0, 0, 7'h7F);
      chk(16'(brightness[0]), 16'h0064, "manual clamp high");
      req(1, 1, 7'h01);
      chk(16'(brightness[1]), 16'h000A, "algo clamp low");
      // Limits word without light enable has no effect.
      i_net_host_model.send(4'h2, 16'h7E85);
      chk(16'(active_upper), 16'h0064, "limits gated upper");
      chk(16'(active_lower), 16'h000A, "limits gated lower");
      req(0, 0, 7'h20);
      chk(16'(brightness[0]), 16'h0020, "manual while local");
      // Host limits 5..125 with light and limit enable.
      i_net_host_model.send(4'h2, 16'hFE85);
      chk(16'(active_upper), 16'h007D, "host upper");
      chk(16'(active_lower), 16'h0005, "host lower");
      chk(16'(auto_light_on), 16'h0000, "auto bits clear");
      req(0, 0, 7'h40);
      chk(16'(brightness[0]), 16'h0020, "panel refused");
      req(1, 0, 7'h7F);
      chk(16'(brightness[0]), 16'h0020, "frozen sensor");
      // Automatic for sensor one only.
      i_net_host_model.send(4'h3, 16'h8000);
      chk(16'(auto_light_on), 16'h0001, "sensor one auto");
      req(1, 0, 7'h7F);
      chk(16'(brightness[0]), 16'h007D, "auto clamp host upper");
      // Override value refused while override bit clear, then taken once it is set.
      i_net_host_model.send(4'h5, 16'h003F);
      chk(16'(brightness[0]), 16'h007D, "override refused");
      i_net_host_model.send(4'h6, 16'h003F);
      chk(16'(brightness[1]), 16'h000A, "override two refused");
      i_net_host_model.send(4'h3, 16'hC040);
      i_net_host_model.send(4'h5, 16'h003F);
      chk(16'(brightness[0]), 16'h003F, "override seeds auto");
      req(1, 0, 7'h40);
      chk(16'(brightness[0]), 16'h0040, "auto continues after override");
      i_net_host_model.send(4'h6, 16'h0002);
      chk(16'(brightness[1]), 16'h0005, "override clamp low");
      // Guide control and manual jogs.
      i_net_host_model.send(4'h4, 16'h0100);
      chk(16'({remote_control, guide_auto_mode}), 16'h0002, "remote manual");
      i_net_host_model.send(4'h4, 16'h0500);
      chk(16'({jog_left, jog_right}), 16'h0002, "jog left");
      i_net_host_model.send(4'h4, 16'h0900);
      chk(16'({jog_left, jog_right}), 16'h0001, "jog right");
      i_net_host_model.send(4'h4, 16'h00FF);
      chk(16'({remote_control, jog_right}), 16'h0000, "reserved bits only");
      // Automatic mode steps, stopping at the extreme limit.
      i_net_host_model.send(4'h4, 16'h0300);
      chk(16'({remote_control, guide_auto_mode}), 16'h0003, "remote auto");
      for (int k = 0; k < 4; k++) begin
         i_net_host_model.send(4'h4, 16'h0700);
         chk(16'(jog_left), 16'h0000, "no jog in auto");
         i_net_host_model.send(4'h4, 16'h0300);
      end
      chk(16'(guide_point), 16'hFFFD, "lower extreme");
      i_net_host_model.send(4'h4, 16'h0B00);
      chk(16'(guide_point), 16'hFFFE, "step up");
      i_net_host_model.send(4'h4, 16'h0B00);
      chk(16'(guide_point), 16'hFFFE, "held bit no step");
      final_report();
   end
endmodule
